// ===== rspm_top.sv
// reset source recording and power mode control
`timescale 1ns/10ps
module rspm_top
  import rspm_pkg::*;
#(
  parameter int POR_DELAY_CYC = RSPM_POR_DELAY_CYC
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic supply_ok,
  input wire logic pin_reset_n,
  input wire logic watchdog_overflow,
  input wire logic missing_clock_timeout,
  input wire logic comparator_out,
  input wire logic flash_error,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata_q,
  output logic sys_reset_q,
  output logic rst_pin_drive_low_q,
  output logic [15:0] reset_vector_q,
  output logic monitor_enable_q,
  output logic missing_clock_en_q,
  output logic cpu_idle_q,
  output logic osc_stop_q
);

  // ********************************
  // reset request combining
  // ********************************
  logic [7:0] pmc_q;
  logic cmp_en_q;
  logic mon_src_q;
  logic [6:0] cause_now;
  logic [6:0] cause_d;
  logic pin_req;
  logic por_req;
  logic mcd_req;
  logic wdt_req;
  logic sw_cell_req;
  logic cmp_req;
  logic flash_req;
  logic pin_flag_q;
  logic por_flag_q;
  logic mcd_flag_q;
  logic wdt_flag_q;
  logic sw_flag_q;
  logic cmp_flag_q;
  logic flash_flag_q;
  logic sw_req;
  logic src_req;
  logic [23:0] por_cnt_q;
  logic por_busy_q;
  logic [2:0] hold_q;
  logic wr_rce;
  logic wr_pmc;

  assign wr_rce = sfr_wr && (sfr_addr == RSPM_RCE_ADDR) && !sys_reset_q;
  assign wr_pmc = sfr_wr && (sfr_addr == RSPM_PMC_ADDR) && !sys_reset_q;
  assign sw_req = wr_rce && sfr_wdata[RSPM_SW_BIT];

  // gated requests of all cells, gathered at their cause positions
  always_comb
  begin
    cause_d = 7'h00;
    cause_d[RSPM_PIN_BIT] = pin_req;
    cause_d[RSPM_POR_BIT] = por_req;
    cause_d[RSPM_MCD_BIT] = mcd_req;
    cause_d[RSPM_WDT_BIT] = wdt_req;
    cause_d[RSPM_SW_BIT] = sw_cell_req;
    cause_d[RSPM_CMP_BIT] = cmp_req;
    cause_d[RSPM_FLASH_BIT] = flash_req;
  end

  // latched flags gathered the same way; spare bit added at read
  always_comb
  begin
    cause_now = 7'h00;
    cause_now[RSPM_PIN_BIT] = pin_flag_q;
    cause_now[RSPM_POR_BIT] = por_flag_q;
    cause_now[RSPM_MCD_BIT] = mcd_flag_q;
    cause_now[RSPM_WDT_BIT] = wdt_flag_q;
    cause_now[RSPM_SW_BIT] = sw_flag_q;
    cause_now[RSPM_CMP_BIT] = cmp_flag_q;
    cause_now[RSPM_FLASH_BIT] = flash_flag_q;
  end

  assign src_req = |cause_d;

  // ********************************
  // power-on delay
  // ********************************
  // counts while supply is good, restarts when it drops
  always_ff @(posedge clk_sys)
  begin
    if (srst || !supply_ok)
    begin
      por_busy_q <= 1'b1;
      por_cnt_q <= 24'h000000;
    end
    else if (por_busy_q)
    begin
      if (por_cnt_q >= 24'(POR_DELAY_CYC - 1))
        por_busy_q <= 1'b0;
      else
        por_cnt_q <= por_cnt_q + 24'h000001;
    end
  end

  // stretch short source pulses, release on clock edge
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      hold_q <= 3'(RSPM_HOLD_CYC);
    else if (src_req)
      hold_q <= 3'(RSPM_HOLD_CYC);
    else if (hold_q != 3'h0)
      hold_q <= hold_q - 3'h1;
  end

  // single internal reset, released on a clock edge
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sys_reset_q <= 1'h1;
    else
      sys_reset_q <= por_busy_q || src_req || (hold_q != 3'h0);
  end

  // reset pin pulled low during power-on delay and hold count, and for a request while the pin is high
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rst_pin_drive_low_q <= 1'h1;
    else
      rst_pin_drive_low_q <= por_busy_q || (src_req && pin_reset_n) || (hold_q != 3'h0);
  end

  // restart address is the same for every source
  always_ff @(posedge clk_sys)
  begin
    reset_vector_q <= RSPM_RESET_VECTOR;
  end

  // ********************************
  // cause flags and enables
  // ********************************
  // external pin cause, always armed
  rspm_cause_cell #(
    .POWER_VALUE(1'h0)
  ) u_pin_cause (
    .clk_sys(clk_sys),
    .srst(srst),
    .power_hold(por_busy_q),
    .source_req(!pin_reset_n),
    .source_en(1'h1),
    .any_req(src_req),
    .in_reset(sys_reset_q),
    .req(pin_req),
    .flag_q(pin_flag_q)
  );

  // power-on and supply monitor cause, preset by power-up
  rspm_cause_cell #(
    .POWER_VALUE(1'h1)
  ) u_por_cause (
    .clk_sys(clk_sys),
    .srst(srst),
    .power_hold(por_busy_q),
    .source_req(!supply_ok),
    .source_en(mon_src_q),
    .any_req(src_req),
    .in_reset(sys_reset_q),
    .req(por_req),
    .flag_q(por_flag_q)
  );

  // missing clock cause, armed by its enable
  rspm_cause_cell #(
    .POWER_VALUE(1'h0)
  ) u_mcd_cause (
    .clk_sys(clk_sys),
    .srst(srst),
    .power_hold(por_busy_q),
    .source_req(missing_clock_timeout),
    .source_en(missing_clock_en_q),
    .any_req(src_req),
    .in_reset(sys_reset_q),
    .req(mcd_req),
    .flag_q(mcd_flag_q)
  );

  // watchdog overflow cause, always armed
  rspm_cause_cell #(
    .POWER_VALUE(1'h0)
  ) u_wdt_cause (
    .clk_sys(clk_sys),
    .srst(srst),
    .power_hold(por_busy_q),
    .source_req(watchdog_overflow),
    .source_en(1'h1),
    .any_req(src_req),
    .in_reset(sys_reset_q),
    .req(wdt_req),
    .flag_q(wdt_flag_q)
  );

  // software force cause, from an accepted register write
  rspm_cause_cell #(
    .POWER_VALUE(1'h0)
  ) u_sw_cause (
    .clk_sys(clk_sys),
    .srst(srst),
    .power_hold(por_busy_q),
    .source_req(sw_req),
    .source_en(1'h1),
    .any_req(src_req),
    .in_reset(sys_reset_q),
    .req(sw_cell_req),
    .flag_q(sw_flag_q)
  );

  // comparator cause, active low output, armed by its enable
  rspm_cause_cell #(
    .POWER_VALUE(1'h0)
  ) u_cmp_cause (
    .clk_sys(clk_sys),
    .srst(srst),
    .power_hold(por_busy_q),
    .source_req(!comparator_out),
    .source_en(cmp_en_q),
    .any_req(src_req),
    .in_reset(sys_reset_q),
    .req(cmp_req),
    .flag_q(cmp_flag_q)
  );

  // flash error cause, always armed
  rspm_cause_cell #(
    .POWER_VALUE(1'h0)
  ) u_flash_cause (
    .clk_sys(clk_sys),
    .srst(srst),
    .power_hold(por_busy_q),
    .source_req(flash_error),
    .source_en(1'h1),
    .any_req(src_req),
    .in_reset(sys_reset_q),
    .req(flash_req),
    .flag_q(flash_flag_q)
  );

  // enables: power-on leaves monitor on, others reset off
  always_ff @(posedge clk_sys)
  begin
    if (srst || por_busy_q)
    begin
      mon_src_q <= 1'b1;
      monitor_enable_q <= 1'b1;
      cmp_en_q <= 1'b0;
      missing_clock_en_q <= 1'b0;
    end
    else if (sys_reset_q)
    begin
      cmp_en_q <= 1'b0;
      missing_clock_en_q <= 1'b0;
      mon_src_q <= cause_now[RSPM_POR_BIT];
      monitor_enable_q <= 1'b1;
    end
    else if (wr_rce)
    begin
      cmp_en_q <= sfr_wdata[RSPM_CMP_BIT];
      missing_clock_en_q <= sfr_wdata[RSPM_MCD_BIT];
      mon_src_q <= sfr_wdata[RSPM_POR_BIT];
    end
  end

  // ********************************
  // power mode control
  // ********************************
  // flags stored; mode bits are write strobes only
  always_ff @(posedge clk_sys)
  begin
    if (srst || sys_reset_q)
    begin
      pmc_q <= RSPM_PMC_RESET;
      cpu_idle_q <= 1'b0;
      osc_stop_q <= 1'b0;
    end
    else
    begin
      if (wr_pmc)
        pmc_q[7:RSPM_GF_LSB] <= sfr_wdata[7:RSPM_GF_LSB];
      if (wr_pmc && sfr_wdata[RSPM_PMC_STOP_BIT])
        osc_stop_q <= 1'b1;
      if (wr_pmc && sfr_wdata[RSPM_PMC_IDLE_BIT])
        cpu_idle_q <= 1'b1;
    end
  end

  // ********************************
  // register read
  // ********************************
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sfr_rdata_q <= 8'h00;
    else if (sfr_rd && sfr_addr == RSPM_PMC_ADDR)
      sfr_rdata_q <= {pmc_q[7:RSPM_GF_LSB], 2'b00};
    else if (sfr_rd && sfr_addr == RSPM_RCE_ADDR)
      sfr_rdata_q <= {1'h0, cause_now};
    else
      sfr_rdata_q <= 8'h00;
  end

endmodule

// ********************************
// cause flag cell
// ********************************
// one cause: gated request, flag kept until the next reset
module rspm_cause_cell
  import rspm_pkg::*;
#(
  parameter logic POWER_VALUE = 1'h0
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic power_hold,
  input wire logic source_req,
  input wire logic source_en,
  input wire logic any_req,
  input wire logic in_reset,
  output logic req,
  output logic flag_q
);

  // a request only counts while its source is armed
  assign req = source_en && source_req;

  // power-up presets; a fresh reset replaces, overlapping ones add
  always_ff @(posedge clk_sys)
  begin
    if (srst || power_hold)
      flag_q <= POWER_VALUE;
    else if (any_req && !in_reset)
      flag_q <= req;
    else if (any_req)
      flag_q <= flag_q || req;
  end

endmodule

// ===== rspm_pkg.sv
// constants for the reset source and power mode block
// Contract
// - power control bits 7:2 are free flags
// - power bit 1 write enters stop, reads 0
// - power bit 0 write enters idle, reads 0
// - hold reset, drive pin low below threshold
// - delay release after supply passes threshold
// - power-on flag set after power-on reset
// - other resets clear power-on flag
// - all resets restart at address zero
// - supply monitor enabled as source after power-on
// - bit 6 read-only flash error cause
// - bit 5 enables comparator reset, shows cause
// - bit 4 write forces reset, shows cause
// - bit 3 read-only watchdog cause
// - bit 2 enables missing clock, shows cause
// - bit 1 enables supply monitor reset source
// - bit 0 read-only pin reset cause
package rspm_pkg;
  localparam logic [7:0] RSPM_PMC_ADDR = 8'h87;
  localparam logic [7:0] RSPM_RCE_ADDR = 8'hEF;
  localparam logic [7:0] RSPM_PMC_RESET = 8'h00;
  localparam int RSPM_PMC_STOP_BIT = 1;
  localparam int RSPM_PMC_IDLE_BIT = 0;
  localparam int RSPM_GF_LSB = 2;
  localparam int RSPM_FLASH_BIT = 6;
  localparam int RSPM_CMP_BIT = 5;
  localparam int RSPM_SW_BIT = 4;
  localparam int RSPM_WDT_BIT = 3;
  localparam int RSPM_MCD_BIT = 2;
  localparam int RSPM_POR_BIT = 1;
  localparam int RSPM_PIN_BIT = 0;
  localparam logic [15:0] RSPM_RESET_VECTOR = 16'h0000;
  localparam int RSPM_CLK_HZ = 20000000;
  localparam int RSPM_POR_DELAY_US = 10000;
  localparam int RSPM_POR_DELAY_CYC = RSPM_POR_DELAY_US * (RSPM_CLK_HZ / 1000000);
  localparam int RSPM_HOLD_CYC = 4;
endpackage

// ===== rspm_properties.sv
// port checks for the reset source block
`timescale 1ns/10ps
module rspm_properties
(
  input logic clk_sys,
  input logic srst,
  input logic supply_ok,
  input logic [7:0] sfr_addr,
  input logic sfr_wr,
  input logic sfr_rd,
  input logic [7:0] sfr_wdata,
  input logic [7:0] sfr_rdata_q,
  input logic sys_reset_q,
  input logic cpu_idle_q,
  input logic osc_stop_q
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // accepted power writes and reads, software reset
  wire wp = sfr_wr && !sys_reset_q && sfr_addr == 8'h87;
  wire rp = sfr_rd && sfr_addr == 8'h87;
  wire ws = sfr_wr && !sys_reset_q && sfr_addr == 8'hEF && sfr_wdata[4];
  a_supply_hold: assert property (!supply_ok |-> ##[1:2] sys_reset_q) else $error("held");
  a_release_wait: assert property ($fell(srst) |-> sys_reset_q [*8]) else $error("early");
  a_supply_release: assert property ($rose(supply_ok) |-> sys_reset_q [*8]) else $error("supply early");
  a_mode_zero: assert property (rp |=> sfr_rdata_q[1:0] == 2'b00) else $error("mode");
  a_spare_zero: assert property (sfr_rd && sfr_addr == 8'hEF |=> !sfr_rdata_q[7]) else $error("spare");
  a_idle_entry: assert property (wp && sfr_wdata[0] |=> cpu_idle_q) else $error("idle");
  a_stop_entry: assert property (wp && sfr_wdata[1] |=> osc_stop_q) else $error("stop");
  a_soft_reset: assert property (ws |=> sys_reset_q) else $error("soft");
  a_flag_keep: assert property (wp ##1 !wp ##1 (rp && !sys_reset_q) |=>
    sfr_rdata_q[7:2] == $past(sfr_wdata[7:2], 3)) else $error("flags");
  cover property (ws);
  cover property ($fell(sys_reset_q));
  cover property (wp ##2 rp);
endmodule
bind rspm_top rspm_properties u_props (.*);

// ===== tb.sv
// self-checking bench for the reset source block
`timescale 1ns/10ps
module tb;
  logic clk_sys = 0, srst = 1, supply_ok = 1, sfr_wr = 0, sfr_rd = 0, sys_reset_q;
  logic rst_pin_drive_low_q, monitor_enable_q, missing_clock_en_q, cpu_idle_q, osc_stop_q;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata_q, req = 0, d;
  logic [15:0] reset_vector_q;
  int seed = 78, failures = 0, checks_done = 0, b, n;
  // clock, design with a short power-on count
  always #25 clk_sys = ~clk_sys;
  rspm_top #(.POR_DELAY_CYC(20)) dut (.*, .pin_reset_n(!req[0]), .watchdog_overflow(req[3]),
    .missing_clock_timeout(req[2]), .comparator_out(!req[5]), .flash_error(req[6]));
  task chk(input logic [16:0] s, input logic [16:0] e, input string nm);
    checks_done++;
    if (s !== e)
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    failures += int'(s !== e);
  endtask
  // expected power register read: flags kept, mode bits read 0
  function automatic logic [7:0] pmc_exp(input logic [7:0] v);
    return {v[7:2], 2'h0};
  endfunction
  task results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // register access, reads compared
  task acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} <= {w, !w, a, v};
    @(posedge clk_sys);
    {sfr_wr, sfr_rd} <= 2'b00;
    @(negedge clk_sys);
    if (!w)
      chk(sfr_rdata_q, v, "rd");
  endtask
  // bounded wait for reset release
  task settle;
    for (n = 0; sys_reset_q !== 1'b0 && n < 200; n++)
      @(negedge clk_sys);
    chk(n < 200, 1, "release");
    if (n >= 200)
      results;
  endtask
  // stimulus
  initial
  begin
    repeat (5) @(posedge clk_sys);
    srst <= 0;
    settle;
    acc(0, 8'hEF, 8'h02);
    chk({monitor_enable_q, reset_vector_q}, 17'h10000, "pwr");
    acc(0, 8'h87, 8'h00);
    acc(1, 8'h87, 8'h03);
    chk({cpu_idle_q, osc_stop_q}, 3, "mode");
    repeat (4)
    begin
      d = 8'($random(seed));
      acc(1, 8'h87, d);
      acc(0, 8'h87, pmc_exp(d));
    end
    acc(1, 8'hEF, 8'h12);
    settle;
    acc(0, 8'hEF, 8'h10);
    @(posedge clk_sys);
    req <= 8'h24;
    repeat (3) @(negedge clk_sys);
    chk({sys_reset_q, missing_clock_en_q}, 0, "gated");
    @(posedge clk_sys);
    req <= 8'h00;
    for (b = 0; b < 7; b++)
      if (b != 1 && b != 4)
      begin
        acc(1, 8'hEF, 8'h26);
        chk(missing_clock_en_q, 1, "mcd_en");
        @(posedge clk_sys);
        req[b] <= 1;
        repeat (2) @(posedge clk_sys);
        req[b] <= 0;
        settle;
        acc(0, 8'hEF, 8'h01 << b);
      end
    acc(1, 8'hEF, 8'h82);
    @(posedge clk_sys);
    supply_ok <= 0;
    repeat (3) @(negedge clk_sys);
    chk({sys_reset_q, rst_pin_drive_low_q}, 3, "held");
    @(posedge clk_sys);
    supply_ok <= 1;
    settle;
    acc(0, 8'hEF, 8'h02);
    results;
  end
endmodule
